// >>> logic/pcs_map.svh
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// Register offsets on the local register port
`define PCS_OFS_CTRL_A      8'h92
`define PCS_OFS_CTRL_B      8'h93
`define PCS_OFS_POLARITY    8'ha2
`define PCS_OFS_PORT_DATA   8'hc0
// Base address pairs: high byte at FIRST + 2*pin, low byte one above
`define PCS_OFS_BASE_FIRST  8'hb0

// Field positions
`define PCS_FLD_PIN_EVEN    3:0
`define PCS_FLD_PIN_ODD     7:4
`define PCS_FLD_POLARITY    7:4
`define PCS_FLD_PORT_DATA   3:0
`define PCS_BIT_HOLD        2
`define PCS_BIT_RMW_PIN     1
`define PCS_BIT_PULLUP      0

// Compare masks
`define PCS_MASK_A15_A0     16'hffff
`define PCS_MASK_A15_A1     16'hfffe
`define PCS_MASK_A15_A2     16'hfffc
`define PCS_MASK_A15_A8     16'hff00

// Reset values
`define PCS_RST_CFG         4'h0
`define PCS_RST_POLARITY    4'h0
`define PCS_RST_PORT_DATA   4'hf
`define PCS_RST_BASE        16'h0000

`endif

// >>> logic/pcs_pkg.sv
package pcs_pkg;

   typedef enum logic [1:0] {
      PCS_MODE_GPIO = 2'h0,
      PCS_MODE_RD   = 2'h1,
      PCS_MODE_WR   = 2'h2,
      PCS_MODE_RDWR = 2'h3
   } pcs_mode_t;

   typedef enum logic [1:0] {
      PCS_CMP_A15_A0 = 2'h0,
      PCS_CMP_A15_A1 = 2'h1,
      PCS_CMP_A15_A2 = 2'h2,
      PCS_CMP_A15_A8 = 2'h3
   } pcs_cmp_t;

   // Mode in the upper two bits, compare width in the lower two
   typedef struct packed {
      pcs_mode_t mode;
      pcs_cmp_t  cmp;
   } pcs_pin_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pcs_reg_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
   } pcs_ext_bus_t;

endpackage

// >>> logic/pcs_pin_sync.sv
`timescale 1ns/10ps
module pcs_pin_sync (
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   input  wire logic [3:0] pin_in,
   output logic [3:0]      pin_out
);

   logic [3:0] stage1_reg;
   logic [3:0] stage2_reg;
   logic [3:0] stage3_reg;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stage1_reg <= 4'hf;
         stage2_reg <= 4'hf;
         stage3_reg <= 4'hf;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // A bit changes only once the second and third stages agree
   for (genvar i = 0; i < 4; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            pin_out[i] <= 1'b1;
         end else if (stage2_reg[i] == stage3_reg[i]) begin
            pin_out[i] <= stage3_reg[i];
         end
      end
   end

endmodule // pcs_pin_sync

// >>> logic/pcs_addr_match.sv
`timescale 1ns/10ps
`include "pcs_map.svh"
module pcs_addr_match (
   input  wire logic [15:0]      addr_in,
   input  wire logic [15:0]      base_in,
   input  wire pcs_pkg::pcs_cmp_t width_in,
   output logic                  match_out
);

   logic [15:0] mask;

   always_comb begin
      case (width_in)
         pcs_pkg::PCS_CMP_A15_A0: begin
            mask = `PCS_MASK_A15_A0;
         end
         pcs_pkg::PCS_CMP_A15_A1: begin
            mask = `PCS_MASK_A15_A1;
         end
         pcs_pkg::PCS_CMP_A15_A2: begin
            mask = `PCS_MASK_A15_A2;
         end
         pcs_pkg::PCS_CMP_A15_A8: begin
            mask = `PCS_MASK_A15_A8;
         end
         default: begin
            mask = `PCS_MASK_A15_A0;
         end
      endcase
      match_out = ((addr_in ^ base_in) & mask) == 16'h0000;
   end

endmodule // pcs_addr_match

// >>> logic/pcs_port.sv
`timescale 1ns/10ps
`include "pcs_map.svh"
module pcs_port (
   input  wire logic                  clk_in,
   input  wire logic                  reset_n_in,
   input  wire pcs_pkg::pcs_reg_req_t reg_req_in,
   output logic [7:0]                 reg_rdata_out,
   input  wire pcs_pkg::pcs_ext_bus_t ext_bus_in,
   input  wire logic                  rmw_read_in,
   input  wire logic                  powerdown_in,
   input  wire logic                  ale_in,
   input  wire logic                  program_store_strobe_in,
   output logic                       ale_out,
   output logic                       program_store_strobe_out,
   output logic                       port0_weak_pullup_en_out,
   input  wire logic [3:0]            pin_in,
   output logic [3:0]                 pin_out,
   output logic [3:0]                 pin_oe_n_out
);

   pcs_pkg::pcs_pin_cfg_t [3:0] cfg_reg;
   logic [3:0]                  polarity_reg;
   logic                        powerdown_strobe_hold_reg;
   logic                        rmw_read_from_pin_reg;
   logic                        pullup_reg;
   logic [3:0]                  latch_reg;
   logic [15:0]                 base_reg [4];
   logic [3:0]                  match_w;
   logic [3:0]                  strobe_w;
   logic [3:0]                  level_next;
   logic [3:0]                  oe_n_next;
   logic [3:0]                  pin_sync_w;
   logic [3:0]                  data_read_w;
   logic                        wr_ctrl_a;
   logic                        wr_ctrl_b;
   logic                        wr_polarity;
   logic                        wr_data;

   assign wr_ctrl_a   = reg_req_in.wr && (reg_req_in.addr == `PCS_OFS_CTRL_A);
   assign wr_ctrl_b   = reg_req_in.wr && (reg_req_in.addr == `PCS_OFS_CTRL_B);
   assign wr_polarity = reg_req_in.wr && (reg_req_in.addr == `PCS_OFS_POLARITY);
   assign wr_data     = reg_req_in.wr && (reg_req_in.addr == `PCS_OFS_PORT_DATA);

   pcs_pin_sync u_pin_sync (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .pin_in     (pin_in),
      .pin_out    (pin_sync_w)
   );

   // Mode and compare-width fields
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_reg <= {4{pcs_pkg::pcs_pin_cfg_t'(`PCS_RST_CFG)}};
      end else if (wr_ctrl_a) begin
         cfg_reg[0] <= pcs_pkg::pcs_pin_cfg_t'(reg_req_in.wdata[`PCS_FLD_PIN_EVEN]);
         cfg_reg[1] <= pcs_pkg::pcs_pin_cfg_t'(reg_req_in.wdata[`PCS_FLD_PIN_ODD]);
      end else if (wr_ctrl_b) begin
         cfg_reg[2] <= pcs_pkg::pcs_pin_cfg_t'(reg_req_in.wdata[`PCS_FLD_PIN_EVEN]);
         cfg_reg[3] <= pcs_pkg::pcs_pin_cfg_t'(reg_req_in.wdata[`PCS_FLD_PIN_ODD]);
      end
   end

   // Polarity and miscellaneous control; bit 3 is not stored
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         polarity_reg              <= `PCS_RST_POLARITY;
         powerdown_strobe_hold_reg <= 1'b0;
         rmw_read_from_pin_reg     <= 1'b0;
         pullup_reg                <= 1'b0;
      end else if (wr_polarity) begin
         polarity_reg              <= reg_req_in.wdata[`PCS_FLD_POLARITY];
         powerdown_strobe_hold_reg <= reg_req_in.wdata[`PCS_BIT_HOLD];
         rmw_read_from_pin_reg     <= reg_req_in.wdata[`PCS_BIT_RMW_PIN];
         pullup_reg                <= reg_req_in.wdata[`PCS_BIT_PULLUP];
      end
   end

   assign port0_weak_pullup_en_out = pullup_reg;

   // Port data latch
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         latch_reg <= `PCS_RST_PORT_DATA;
      end else if (wr_data) begin
         latch_reg <= reg_req_in.wdata[`PCS_FLD_PORT_DATA];
      end
   end

   // Per-pin base address, comparator and output selection
   for (genvar i = 0; i < 4; i++) begin : g_pin
      logic       wr_hi;
      logic       wr_lo;
      logic [7:0] ofs_hi;

      assign ofs_hi = `PCS_OFS_BASE_FIRST + 8'(2 * i);
      assign wr_hi  = reg_req_in.wr && (reg_req_in.addr == ofs_hi);
      assign wr_lo  = reg_req_in.wr && (reg_req_in.addr == ofs_hi + 8'h01);

      always_ff @(posedge clk_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            base_reg[i] <= `PCS_RST_BASE;
         end else if (wr_hi) begin
            base_reg[i][15:8] <= reg_req_in.wdata;
         end else if (wr_lo) begin
            base_reg[i][7:0] <= reg_req_in.wdata;
         end
      end

      pcs_addr_match u_match (
         .addr_in   (ext_bus_in.addr),
         .base_in   (base_reg[i]),
         .width_in  (cfg_reg[i].cmp),
         .match_out (match_w[i])
      );

      always_comb begin
         case (cfg_reg[i].mode)
            pcs_pkg::PCS_MODE_GPIO: begin
               strobe_w[i] = 1'b0;
            end
            pcs_pkg::PCS_MODE_RD: begin
               strobe_w[i] = match_w[i] && ext_bus_in.rd;
            end
            pcs_pkg::PCS_MODE_WR: begin
               strobe_w[i] = match_w[i] && ext_bus_in.wr;
            end
            pcs_pkg::PCS_MODE_RDWR: begin
               strobe_w[i] = match_w[i] && (ext_bus_in.rd || ext_bus_in.wr);
            end
            default: begin
               strobe_w[i] = 1'b0;
            end
         endcase
      end

      // Quasi-bidirectional pin drives only low; strobe pins are always driven
      assign level_next[i] = (cfg_reg[i].mode == pcs_pkg::PCS_MODE_GPIO) ?
                             latch_reg[i] :
                             ~(strobe_w[i] ^ polarity_reg[i]);
      assign oe_n_next[i]  = (cfg_reg[i].mode == pcs_pkg::PCS_MODE_GPIO) ?
                             latch_reg[i] : 1'b0;
   end

   // Pins follow the access level one cycle later, as long as it lasts
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_out      <= 4'hf;
         pin_oe_n_out <= 4'hf;
      end else begin
         pin_out      <= level_next;
         pin_oe_n_out <= oe_n_next;
      end
   end

   // Address latch and program store strobes
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ale_out                  <= 1'b1;
         program_store_strobe_out <= 1'b1;
      end else if (powerdown_in) begin
         ale_out                  <= powerdown_strobe_hold_reg;
         program_store_strobe_out <= powerdown_strobe_hold_reg;
      end else begin
         ale_out                  <= ale_in;
         program_store_strobe_out <= program_store_strobe_in;
      end
   end

   // Read-modify-write takes the latch unless pin reading is selected
   assign data_read_w = (rmw_read_in && !rmw_read_from_pin_reg) ?
                        latch_reg : pin_sync_w;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_req_in.rd) begin
         reg_rdata_out <= 8'h00;
         if (reg_req_in.addr == `PCS_OFS_CTRL_A) begin
            reg_rdata_out <= {cfg_reg[1], cfg_reg[0]};
         end else if (reg_req_in.addr == `PCS_OFS_CTRL_B) begin
            reg_rdata_out <= {cfg_reg[3], cfg_reg[2]};
         end else if (reg_req_in.addr == `PCS_OFS_POLARITY) begin
            reg_rdata_out <= {polarity_reg, 1'b0, powerdown_strobe_hold_reg,
                              rmw_read_from_pin_reg, pullup_reg};
         end else if (reg_req_in.addr == `PCS_OFS_PORT_DATA) begin
            reg_rdata_out <= {4'h0, data_read_w};
         end else begin
            for (int k = 0; k < 4; k++) begin
               if (reg_req_in.addr == `PCS_OFS_BASE_FIRST + 8'(2 * k)) begin
                  reg_rdata_out <= base_reg[k][15:8];
               end
               if (reg_req_in.addr == `PCS_OFS_BASE_FIRST + 8'(2 * k + 1)) begin
                  reg_rdata_out <= base_reg[k][7:0];
               end
            end
         end
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence s_ctrl_a_write;
      wr_ctrl_a;
   endsequence

   sequence s_polarity_write;
      wr_polarity;
   endsequence

   sequence s_data_write;
      wr_data ##1 !reg_req_in.wr;
   endsequence

   sequence s_rmw_latch_read;
      reg_req_in.rd && (reg_req_in.addr == `PCS_OFS_PORT_DATA) &&
      rmw_read_in && !rmw_read_from_pin_reg;
   endsequence

   chk_ctrl_a_layout: assert property (
      s_ctrl_a_write |=> (cfg_reg[0] == $past(reg_req_in.wdata[3:0])) &&
                         (cfg_reg[1] == $past(reg_req_in.wdata[7:4])))
      else $error("control A fields not stored in place");

   chk_ctrl_b_layout: assert property (
      wr_ctrl_b |=> (cfg_reg[2] == $past(reg_req_in.wdata[3:0])) &&
                    (cfg_reg[3] == $past(reg_req_in.wdata[7:4])))
      else $error("control B fields not stored in place");

   chk_polarity_layout: assert property (
      s_polarity_write |=> (polarity_reg == $past(reg_req_in.wdata[7:4])) &&
                           (powerdown_strobe_hold_reg == $past(reg_req_in.wdata[2])))
      else $error("polarity register fields misplaced");

   chk_pullup_follows: assert property (
      s_polarity_write ##1 !wr_polarity |->
         port0_weak_pullup_en_out == $past(reg_req_in.wdata[0]))
      else $error("port 0 pull-up does not follow its bit");

   chk_powerdown_hold: assert property (
      powerdown_in |=> (ale_out == $past(powerdown_strobe_hold_reg)) &&
                       (program_store_strobe_out == $past(powerdown_strobe_hold_reg)))
      else $error("power-down strobe level wrong");

   chk_rmw_latch_path: assert property (
      s_rmw_latch_read |=> reg_rdata_out == {4'h0, $past(latch_reg)})
      else $error("read-modify-write did not read the latch");

   for (genvar j = 0; j < 4; j++) begin : g_chk
      logic [15:0] diff;
      assign diff = ext_bus_in.addr ^ base_reg[j];

      chk_full_compare: assert property (
         (cfg_reg[j].cmp == pcs_pkg::PCS_CMP_A15_A0) |-> match_w[j] == (diff == 16'h0000))
         else $error("full address compare wrong");

      chk_two_byte_compare: assert property (
         (cfg_reg[j].cmp == pcs_pkg::PCS_CMP_A15_A1) |-> match_w[j] == (diff[15:1] == 15'h0))
         else $error("two-byte region compare wrong");

      chk_four_byte_compare: assert property (
         (cfg_reg[j].cmp == pcs_pkg::PCS_CMP_A15_A2) |-> match_w[j] == (diff[15:2] == 14'h0))
         else $error("four-byte region compare wrong");

      chk_page_compare: assert property (
         (cfg_reg[j].cmp == pcs_pkg::PCS_CMP_A15_A8) |-> match_w[j] == (diff[15:8] == 8'h00))
         else $error("page compare wrong");

      chk_base_high: assert property (
         reg_req_in.wr && (reg_req_in.addr == `PCS_OFS_BASE_FIRST + 8'(2 * j)) |=>
            base_reg[j][15:8] == $past(reg_req_in.wdata))
         else $error("base address high byte not stored");

      chk_base_low: assert property (
         reg_req_in.wr && (reg_req_in.addr == `PCS_OFS_BASE_FIRST + 8'(2 * j + 1)) |=>
            base_reg[j][7:0] == $past(reg_req_in.wdata))
         else $error("base address low byte not stored");

      chk_gpio_drive: assert property (
         (cfg_reg[j].mode == pcs_pkg::PCS_MODE_GPIO) |=>
            (pin_out[j] == $past(latch_reg[j])) && (pin_oe_n_out[j] == $past(latch_reg[j])))
         else $error("general purpose pin not following latch");

      chk_data_to_pin: assert property (
         (cfg_reg[j].mode == pcs_pkg::PCS_MODE_GPIO) && !wr_ctrl_a && !wr_ctrl_b
         ##0 s_data_write |=> pin_out[j] == $past(reg_req_in.wdata[j], 2))
         else $error("port data write not seen on pin");

      chk_read_strobe: assert property (
         (cfg_reg[j].mode == pcs_pkg::PCS_MODE_RD) && match_w[j] |=>
            pin_out[j] == ($past(ext_bus_in.rd) ~^ $past(polarity_reg[j])))
         else $error("read strobe level wrong");

      chk_write_strobe: assert property (
         (cfg_reg[j].mode == pcs_pkg::PCS_MODE_WR) && match_w[j] |=>
            pin_out[j] == ($past(ext_bus_in.wr) ~^ $past(polarity_reg[j])))
         else $error("write strobe level wrong");

      chk_read_ignores_wr: assert property (
         (cfg_reg[j].mode == pcs_pkg::PCS_MODE_RD) && ext_bus_in.wr && !ext_bus_in.rd |=>
            pin_out[j] != $past(polarity_reg[j]))
         else $error("read strobe fired on a write");

      chk_write_ignores_rd: assert property (
         (cfg_reg[j].mode == pcs_pkg::PCS_MODE_WR) && ext_bus_in.rd && !ext_bus_in.wr |=>
            pin_out[j] != $past(polarity_reg[j]))
         else $error("write strobe fired on a read");

      chk_rdwr_strobe: assert property (
         (cfg_reg[j].mode == pcs_pkg::PCS_MODE_RDWR) && match_w[j] &&
         (ext_bus_in.rd || ext_bus_in.wr) |=> pin_out[j] == $past(polarity_reg[j]))
         else $error("read/write strobe not active");

      chk_strobe_idle: assert property (
         (cfg_reg[j].mode != pcs_pkg::PCS_MODE_GPIO) && !ext_bus_in.rd && !ext_bus_in.wr
         |=> (pin_out[j] != $past(polarity_reg[j])) && !pin_oe_n_out[j])
         else $error("strobe not idle between accesses");
   end

endmodule // pcs_port

// >>> testbench/pcs_periph_model.sv
`timescale 1ns/10ps
module pcs_periph_model (
   input  wire logic [3:0] pin_out_in,
   input  wire logic [3:0] pin_oe_n_in,
   input  wire logic [3:0] pull_low_in,
   output logic [3:0]      pin_level_out
);
   // A driven pin wins; a released pin sits at the pull-up unless a peripheral sinks it
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_level_out[i] = !pin_oe_n_in[i] ? pin_out_in[i] : !pull_low_in[i];
      end
   end
endmodule // pcs_periph_model

// >>> testbench/tb.sv
`timescale 1ns/10ps
module tb;
   logic                  clk;
   logic                  reset_n;
   pcs_pkg::pcs_reg_req_t req;
   pcs_pkg::pcs_ext_bus_t bus;
   logic                  rmw_read;
   logic                  powerdown;
   logic                  ale;
   logic                  pss;
   logic [3:0]            pull_low;
   logic [7:0]            rdata;
   logic                  ale_q;
   logic                  pss_q;
   logic                  pullup_en;
   logic [3:0]            pin_lvl;
   logic [3:0]            pin_q;
   logic [3:0]            pin_oe_n;
   int                    fails;
   int                    check_count;
   logic [31:0]           seed;
   logic [31:0]           r;
   logic [15:0]           base;
   logic [15:0]           mask;
   logic [15:0]           a;
   logic [1:0]            mode;
   logic [1:0]            cmp;
   logic                  pol;
   logic [7:0]            cfg;
   logic [7:0]            latch;
   int                    p;
   logic [7:0]            regs [11] = '{8'h92, 8'h93, 8'ha2, 8'hb0, 8'hb1, 8'hb2, 8'hb3,
                                        8'hb4, 8'hb5, 8'hb6, 8'hb7};

   pcs_port dut_u (
      .clk_in                   (clk),
      .reset_n_in               (reset_n),
      .reg_req_in               (req),
      .reg_rdata_out            (rdata),
      .ext_bus_in               (bus),
      .rmw_read_in              (rmw_read),
      .powerdown_in             (powerdown),
      .ale_in                   (ale),
      .program_store_strobe_in  (pss),
      .ale_out                  (ale_q),
      .program_store_strobe_out (pss_q),
      .port0_weak_pullup_en_out (pullup_en),
      .pin_in                   (pin_lvl),
      .pin_out                  (pin_q),
      .pin_oe_n_out             (pin_oe_n)
   );

   pcs_periph_model periph_u (
      .pin_out_in    (pin_q),
      .pin_oe_n_in   (pin_oe_n),
      .pull_low_in   (pull_low),
      .pin_level_out (pin_lvl)
   );

   always #20 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [15:0] cmp_mask(input logic [1:0] c);
      case (c)
         2'h0: return 16'hffff;
         2'h1: return 16'hfffe;
         2'h2: return 16'hfffc;
         default: return 16'hff00;
      endcase
   endfunction

   // Expected pin level for the pin under test, from mode, width, base and polarity
   function automatic logic strobe_level(input logic [15:0] ad, input logic r_in,
                                         input logic w_in);
      logic hit;
      hit = ((ad & cmp_mask(cmp)) == (base & cmp_mask(cmp)))
            && ((mode[0] && r_in) || (mode[1] && w_in));
      return pol ? hit : !hit;
   endfunction

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic complete_run();
      if (fails == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd_check(input string name, input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clk);
      req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      check(name, exp, rdata);
   endtask

   task automatic bus_cycle(input logic [15:0] ad, input logic r_in, input logic w_in);
      logic act;
      logic idle;
      act = strobe_level(ad, r_in, w_in);
      idle = strobe_level(ad, 1'b0, 1'b0);
      @(posedge clk);
      bus <= '{addr: ad, rd: r_in, wr: w_in};
      repeat (2) begin
         @(posedge clk);
         @(negedge clk);
         check("strobe active", {7'h0, act}, {7'h0, pin_q[p]});
      end
      @(posedge clk);
      bus <= '{addr: ad, rd: 1'b0, wr: 1'b0};
      @(posedge clk);
      @(negedge clk);
      check("strobe idle", {7'h0, idle}, {7'h0, pin_q[p]});
      check("strobe oe", 8'h00, {7'h0, pin_oe_n[p]});
      check("gpio beside", latch & ~(8'h1 << p), {4'h0, pin_q} & ~(8'h1 << p));
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      complete_run();
   end

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      req = '0;
      bus = '0;
      rmw_read = 1'b0;
      powerdown = 1'b0;
      ale = 1'b0;
      pss = 1'b0;
      pull_low = 4'h0;
      fails = 0;
      check_count = 0;
      seed = 32'd91;
      latch = 8'h0f;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      check("pin reset", 8'h0f, {4'h0, pin_q});
      check("oe reset", 8'h0f, {4'h0, pin_oe_n});
      repeat (4) @(posedge clk);
      foreach (regs[i]) rd_check("reg reset", regs[i], 8'h00);
      rd_check("port reset", 8'hc0, 8'h0f);
      foreach (regs[i]) begin
         r = rnd();
         reg_wr(regs[i], r[7:0]);
         if (regs[i] == 8'ha2) r[3] = 1'b0;
         rd_check("readback", regs[i], r[7:0]);
      end
      reg_wr(8'h55, 8'hff);
      rd_check("unmapped", 8'h55, 8'h00);
      reg_wr(8'h92, 8'h00);
      reg_wr(8'h93, 8'h00);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         latch = {4'h0, r[3:0]};
         reg_wr(8'hc0, r[7:0]);
         @(posedge clk);
         @(negedge clk);
         check("gpio out", latch, {4'h0, pin_q});
         check("gpio oe", latch, {4'h0, pin_oe_n});
         repeat (4) @(posedge clk);
         rd_check("gpio in", 8'hc0, latch);
      end
      latch = 8'h0f;
      reg_wr(8'hc0, latch);
      pull_low <= 4'h2;
      repeat (5) @(posedge clk);
      rmw_read <= 1'b1;
      reg_wr(8'ha2, 8'h00);
      rd_check("rmw latch", 8'hc0, 8'h0f);
      reg_wr(8'ha2, 8'h02);
      rd_check("rmw pin", 8'hc0, 8'h0d);
      rmw_read <= 1'b0;
      reg_wr(8'ha2, 8'h00);
      rd_check("plain read", 8'hc0, 8'h0d);
      pull_low <= 4'h0;
      for (int h = 0; h < 2; h++) begin
         reg_wr(8'ha2, h ? 8'h04 : 8'h01);
         @(posedge clk);
         powerdown <= 1'b1;
         ale <= h[0] ? 1'b0 : 1'b1;
         pss <= h[0] ? 1'b0 : 1'b1;
         @(posedge clk);
         @(negedge clk);
         check("pullup", {7'h0, !h[0]}, {7'h0, pullup_en});
         @(posedge clk);
         @(negedge clk);
         check("ale hold", {7'h0, h[0]}, {7'h0, ale_q});
         check("store hold", {7'h0, h[0]}, {7'h0, pss_q});
         @(posedge clk);
         powerdown <= 1'b0;
      end
      for (int i = 0; i < 48; i++) begin
         p = i % 4;
         mode = 2'(i / 4 % 3 + 1);
         cmp = 2'(i / 12);
         r = rnd();
         pol = r[0];
         base = r[31:16];
         reg_wr(8'hb0 + 8'(2 * p), base[15:8]);
         reg_wr(8'hb1 + 8'(2 * p), base[7:0]);
         cfg = 8'({mode, cmp}) << (4 * (p % 2));
         reg_wr(8'h92, (p < 2) ? cfg : 8'h00);
         reg_wr(8'h93, (p < 2) ? 8'h00 : cfg);
         reg_wr(8'ha2, 8'(pol) << (4 + p));
         for (int k = 0; k < 4; k++) begin
            r = rnd();
            mask = cmp_mask(cmp);
            a = (base & mask) | (r[15:0] & ~mask);
            if (k == 1) a = a ^ (mask & (~mask + 16'h1));
            if (k == 3) a = a ^ (16'h8000 >> r[18:16]);
            bus_cycle(a, r[20], !r[20]);
         end
      end
      p = 0;
      mode = 2'h2;
      cmp = 2'h2;
      pol = 1'b1;
      base = 16'h1234;
      reg_wr(8'hb0, 8'h12);
      reg_wr(8'hb1, 8'h34);
      reg_wr(8'h92, 8'h0a);
      reg_wr(8'h93, 8'h00);
      reg_wr(8'ha2, 8'h10);
      for (int k = 0; k < 8; k++) bus_cycle(16'h1232 + 16'(k), 1'b0, 1'b1);
      complete_run();
   end
endmodule // tb
